// ---- common/gvm_pkg.sv ----
// Constants shared by both ends of the video register link.
// Assumes one clock, pclk, drives both ends.
`default_nettype none
package gvm_pkg;
   // ************************************************************
   // Device map
   // ************************************************************
   localparam int          GVM_AW       = 11;
   localparam int          GVM_NSPR     = 16;
   localparam logic [10:0] GVM_CFG_OFS  = 11'h000;
   localparam logic [10:0] GVM_STS_OFS  = 11'h004;
   localparam logic [10:0] GVM_TAB_BASE = 11'h700;
   localparam logic [10:0] GVM_TAB_LAST = 11'h77f;
   localparam logic [10:0] GVM_WORD     = 11'h004;
   localparam int          GVM_IDX_LSB  = 3;
   localparam int          GVM_IDX_MSB  = 6;
   localparam int          GVM_HI_BIT   = 2;
   // Configuration fields
   localparam int          GVM_MAP_LSB  = 0;
   localparam int          GVM_MAP_MSB  = 1;
   localparam logic [1:0]  GVM_MAP_MAX  = 2'h2;
   localparam int          GVM_EN_BIT   = 2;
   localparam int          GVM_CLIP_LSB = 3;
   localparam int          GVM_CLIP_MSB = 4;
   localparam logic [31:0] GVM_CFG_RST  = 32'h0000_0000;
   // Status fields
   localparam int          GVM_V_LSB    = 10;
   localparam int          GVM_V_MSB    = 19;
   localparam logic [3:0]  GVM_HIT_NONE = 4'h0;
   // Descriptor fields
   localparam int          GVM_X_LSB    = 0;
   localparam int          GVM_Y_LSB    = 16;
   localparam int          GVM_RANK_LSB = 40;
   localparam int          GVM_W_LSB    = 48;
   localparam int          GVM_H_LSB    = 56;
   // ************************************************************
   // Scan timing
   // ************************************************************
   localparam logic [9:0]  GVM_H_LAST   = 10'h31f;
   localparam logic [9:0]  GVM_V_LAST   = 10'h20c;
   localparam logic [9:0]  GVM_V_BLANK  = 10'h1e0;
   // ************************************************************
   // Controller APB map
   // ************************************************************
   localparam logic [31:0] GVM_A_TGT    = 32'h0000_0000;
   localparam logic [31:0] GVM_A_WLO    = 32'h0000_0004;
   localparam logic [31:0] GVM_A_WHI    = 32'h0000_0008;
   localparam logic [31:0] GVM_A_CMD    = 32'h0000_000c;
   localparam logic [31:0] GVM_A_RES    = 32'h0000_0010;
   localparam logic [31:0] GVM_A_ISTAT  = 32'h0000_0014;
   localparam logic [31:0] GVM_A_IMASK  = 32'h0000_0018;
   localparam logic [31:0] GVM_A_STATE  = 32'h0000_001c;
   localparam int          GVM_GO_BIT   = 0;
   localparam int          GVM_WR_BIT   = 1;
   localparam int          GVM_PAIR_BIT = 2;
   typedef enum logic [3:0] {
      GVM_IDLE  = 4'b0001,
      GVM_POLL  = 4'b0010,
      GVM_XFER  = 4'b0100,
      GVM_XFER2 = 4'b1000
   } gvm_state_t;
endpackage : gvm_pkg
`default_nettype wire

// ---- common/gvm_if.sv ----
// Word bus joining the controller to the video register block.
// Assumes both ends run on the same clock.
`default_nettype none
interface gvm_if;
   logic [gvm_pkg::GVM_AW-1:0] addr;
   logic                       rd;
   logic                       wr;
   logic [31:0]                wdata;
   logic [31:0]                rdata;
   logic                       ack;
   modport dev  (input addr, rd, wr, wdata, output rdata, ack);
   modport host (output addr, rd, wr, wdata, input rdata, ack);
endinterface : gvm_if
`default_nettype wire

// ---- design/gvm_device.sv ----
// Video register block: configuration, scan status, sprite table
// and sprite over tile pixel choice.
// Assumes the controller holds rd or wr until ack, same clock.
// Function
// - Registers reached only via slave bus
// - Write-only config, tilemap select 0..2
// - Config bit 2 enables collision check
// - Any config write starts clip playback at next frame
// - Software writes unused config bits zero
// - Read-only status: column and line counts
// - Status carries collision class code
// - Status refreshed every clock cycle
// - Sixteen eight-byte sprite entries, read/write
// - Sprite entry fields decoded by position
// - Check only sprite against tiles, enabled
// - No frame interrupt; software polls line
// - Software writes only during vertical blanking
// - Writes take effect at next frame
// - Only aligned full-word accesses
// - Descriptor updates written atomically
// - Higher overlay rank sprite shown
// - Nonzero colour overrides, zero transparent
//
// The APB interface to the registers is this design's own decision.
`default_nettype none
module gvm_device #(
   parameter logic [9:0] H_LAST = gvm_pkg::GVM_H_LAST  // Last column of a line
) (
   input  wire logic                            pclk,
   input  wire logic                            presetn,
   gvm_if.dev                                   bus,
   input  wire logic [7:0]                      tile_palette,
   input  wire logic [gvm_pkg::GVM_NSPR*8-1:0]  sprite_palette,
   input  wire logic [3:0]                      hit_class,
   output logic      [9:0]                      scan_x,
   output logic      [9:0]                      scan_y,
   output logic      [1:0]                      tilemap_sel,
   output logic                                 hit_check_en,
   output logic      [1:0]                      audio_clip,
   output logic                                 audio_start,
   output logic      [7:0]                      pixel_palette,
   output logic      [gvm_pkg::GVM_NSPR*64-1:0] active_table
);
   import gvm_pkg::*;

   // ************************************************************
   // Declarations
   // ************************************************************
   logic [9:0]  h_reg;
   logic [9:0]  v_reg;
   logic [31:0] cfg_reg;
   logic [1:0]  map_reg;
   logic        en_reg;
   logic [1:0]  clip_reg;
   logic        pend_reg;
   logic        start_reg;
   logic [31:0] status_reg;
   logic [31:0] rdata_reg;
   logic        ack_reg;
   logic [7:0]  pixel_reg;
   logic [63:0] stage_reg [GVM_NSPR];
   logic [63:0] act_reg   [GVM_NSPR];
   logic [GVM_NSPR-1:0] vis;
   logic        frame_start;
   logic        take;
   logic        sel_cfg;
   logic        sel_sts;
   logic        sel_tab;
   logic        wr_cfg;
   logic [3:0]  tab_idx;
   logic        tab_hi;
   logic [7:0]  best_pal;

   // ************************************************************
   // Bus decode
   // ************************************************************
   // slave bus port
   assign take    = (bus.rd | bus.wr) & ~ack_reg;
   assign sel_cfg = (bus.addr == GVM_CFG_OFS);
   assign sel_sts = (bus.addr == GVM_STS_OFS);
   assign sel_tab = (bus.addr >= GVM_TAB_BASE) && (bus.addr <= GVM_TAB_LAST);
   assign tab_idx = bus.addr[GVM_IDX_MSB:GVM_IDX_LSB];
   assign tab_hi  = bus.addr[GVM_HI_BIT];
   assign wr_cfg  = take & bus.wr & sel_cfg;
   assign bus.ack   = ack_reg;
   assign bus.rdata = rdata_reg;

   // One-cycle acknowledge after each taken request
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ack_reg <= 1'b0;
      end else begin
         ack_reg <= take;
      end
   end

   // Read data; config is write-only and reads zero
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rdata_reg <= 32'h0000_0000;
      end else if (take && bus.rd) begin
         if (sel_sts) begin
            rdata_reg <= status_reg;
         end else if (sel_tab) begin
            rdata_reg <= tab_hi ? stage_reg[tab_idx][63:32] : stage_reg[tab_idx][31:0];
         end else begin
            rdata_reg <= 32'h0000_0000;
         end
      end
   end

   // ************************************************************
   // Scan position
   // ************************************************************
   assign frame_start = (h_reg == H_LAST) && (v_reg == GVM_V_LAST);

   // Column and line counters over the full raster
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         h_reg <= 10'h000;
         v_reg <= 10'h000;
      end else if (h_reg == H_LAST) begin
         h_reg <= 10'h000;
         v_reg <= (v_reg == GVM_V_LAST) ? 10'h000 : v_reg + 10'h001;
      end else begin
         h_reg <= h_reg + 10'h001;
      end
   end

   // ************************************************************
   // Configuration
   // ************************************************************
   // zero at reset
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cfg_reg <= GVM_CFG_RST;
      end else if (wr_cfg) begin
         cfg_reg <= bus.wdata;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         map_reg  <= GVM_CFG_RST[GVM_MAP_MSB:GVM_MAP_LSB];
         en_reg   <= GVM_CFG_RST[GVM_EN_BIT];
         clip_reg <= GVM_CFG_RST[GVM_CLIP_MSB:GVM_CLIP_LSB];
      end else if (frame_start) begin
         if (cfg_reg[GVM_MAP_MSB:GVM_MAP_LSB] <= GVM_MAP_MAX) begin
            map_reg <= cfg_reg[GVM_MAP_MSB:GVM_MAP_LSB];
         end
         en_reg   <= cfg_reg[GVM_EN_BIT];
         clip_reg <= cfg_reg[GVM_CLIP_MSB:GVM_CLIP_LSB];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pend_reg  <= 1'b0;
         start_reg <= 1'b0;
      end else begin
         pend_reg  <= wr_cfg | (pend_reg & ~frame_start);
         start_reg <= frame_start & pend_reg;
      end
   end

   assign tilemap_sel  = map_reg;
   assign hit_check_en = en_reg;
   assign audio_clip   = clip_reg;
   assign audio_start  = start_reg;
   assign scan_x       = h_reg;
   assign scan_y       = v_reg;

   // ************************************************************
   // Status
   // ************************************************************
   // refresh each cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         status_reg <= 32'h0000_0000;
      end else begin
         status_reg <= {8'h00, en_reg ? hit_class : GVM_HIT_NONE, v_reg, h_reg};
      end
   end

   // ************************************************************
   // Sprite table
   // ************************************************************
   genvar gi;
   generate
      for (gi = 0; gi < GVM_NSPR; gi++) begin : g_spr
         logic [15:0] sx;
         logic [15:0] sy;
         logic [16:0] ex;
         logic [16:0] ey;
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               stage_reg[gi] <= 64'h0000_0000_0000_0000;
            end else if (take && bus.wr && sel_tab && tab_idx == 4'(gi)) begin
               if (tab_hi) begin
                  stage_reg[gi][63:32] <= bus.wdata;
               end else begin
                  stage_reg[gi][31:0] <= bus.wdata;
               end
            end
         end
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               act_reg[gi] <= 64'h0000_0000_0000_0000;
            end else if (frame_start) begin
               act_reg[gi] <= stage_reg[gi];
            end
         end
         assign sx = act_reg[gi][GVM_X_LSB+:16];
         assign sy = act_reg[gi][GVM_Y_LSB+:16];
         assign ex = {1'b0, sx} + {9'h000, act_reg[gi][GVM_W_LSB+:8]};
         assign ey = {1'b0, sy} + {9'h000, act_reg[gi][GVM_H_LSB+:8]};
         assign vis[gi] = ({6'h00, h_reg} >= sx) && ({7'h00, h_reg} < ex)
                       && ({6'h00, v_reg} >= sy) && ({7'h00, v_reg} < ey)
                       && (sprite_palette[gi*8+:8] != 8'h00);
         assign active_table[gi*64+:64] = act_reg[gi];
      end
   endgenerate

   // ************************************************************
   // Pixel choice
   // ************************************************************
   // highest rank wins
   always_comb begin
      logic [3:0] best_rank;
      logic       found;
      best_rank = 4'h0;
      found     = 1'b0;
      best_pal  = tile_palette;
      for (int i = 0; i < GVM_NSPR; i++) begin
         if (vis[i] && (!found || act_reg[i][GVM_RANK_LSB+:4] > best_rank)) begin
            found     = 1'b1;
            best_rank = act_reg[i][GVM_RANK_LSB+:4];
            best_pal  = sprite_palette[i*8+:8];
         end
      end
   end

   // Registered pixel colour index
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pixel_reg <= 8'h00;
      end else begin
         pixel_reg <= best_pal;
      end
   end

   assign pixel_palette = pixel_reg;

endmodule : gvm_device
`default_nettype wire

// ---- design/gvm_host.sv ----
// Controller end: takes orders over APB and runs word transfers on
// the video register link, gating writes to vertical blanking.
// Assumes the device acknowledges each request once.
`default_nettype none
module gvm_host (
   input  wire logic        pclk,
   input  wire logic        presetn,
   gvm_if.host              bus,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   output logic             irq
);
   import gvm_pkg::*;

   // ************************************************************
   // Declarations
   // ************************************************************
   gvm_state_t  state_reg;
   logic [10:0] tgt_reg;
   logic [31:0] wlo_reg;
   logic [31:0] whi_reg;
   logic        cpair_reg;
   logic [31:0] res_reg;
   logic [9:0]  line_reg;
   logic [1:0]  istat_reg;
   logic [1:0]  imask_reg;
   logic [31:0] prdata_reg;
   logic [10:0] addr_reg;
   logic        rd_reg;
   logic        wr_reg;
   logic [31:0] wdata_reg;
   logic        done_ev;
   logic        err_ev;
   logic        apb_wr;
   logic        apb_rd;
   logic        go;

   assign apb_wr  = psel & penable & pwrite;
   assign apb_rd  = psel & penable & ~pwrite;
   assign go      = apb_wr && (paddr == GVM_A_CMD) && pwdata[GVM_GO_BIT]
                 && (state_reg == GVM_IDLE);
   assign pready  = 1'b1;
   assign pslverr = 1'b0;
   assign prdata  = prdata_reg;
   assign irq     = |(istat_reg & imask_reg);
   assign bus.addr  = addr_reg;
   assign bus.rd    = rd_reg;
   assign bus.wr    = wr_reg;
   assign bus.wdata = wdata_reg;

   // ************************************************************
   // APB registers
   // ************************************************************
   // Order registers written by software
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tgt_reg   <= 11'h000;
         wlo_reg   <= 32'h0000_0000;
         whi_reg   <= 32'h0000_0000;
         cpair_reg <= 1'b0;
         imask_reg <= 2'h0;
      end else if (apb_wr) begin
         if (paddr == GVM_A_TGT) begin
            tgt_reg <= pwdata[10:0];
         end else if (paddr == GVM_A_WLO) begin
            wlo_reg <= pwdata;
         end else if (paddr == GVM_A_WHI) begin
            whi_reg <= pwdata;
         end else if (paddr == GVM_A_IMASK) begin
            imask_reg <= pwdata[1:0];
         end else if (go) begin
            cpair_reg <= pwdata[GVM_PAIR_BIT];
         end
      end
   end

   // Read data captured in the setup cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_reg <= 32'h0000_0000;
      end else if (psel && !penable) begin
         if (paddr == GVM_A_TGT) begin
            prdata_reg <= {21'h000000, tgt_reg};
         end else if (paddr == GVM_A_WLO) begin
            prdata_reg <= wlo_reg;
         end else if (paddr == GVM_A_WHI) begin
            prdata_reg <= whi_reg;
         end else if (paddr == GVM_A_RES) begin
            prdata_reg <= res_reg;
         end else if (paddr == GVM_A_ISTAT) begin
            prdata_reg <= {30'h00000000, istat_reg};
         end else if (paddr == GVM_A_IMASK) begin
            prdata_reg <= {30'h00000000, imask_reg};
         end else if (paddr == GVM_A_STATE) begin
            prdata_reg <= {21'h000000, line_reg, state_reg != GVM_IDLE};
         end else begin
            prdata_reg <= 32'h0000_0000;
         end
      end
   end

   // Sticky events, cleared by read, set wins
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         istat_reg <= 2'h0;
      end else begin
         istat_reg <= (istat_reg & {2{~(apb_rd && paddr == GVM_A_ISTAT)}})
                    | {err_ev, done_ev};
      end
   end

   // ************************************************************
   // Link transfers
   // ************************************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg <= GVM_IDLE;
         addr_reg  <= 11'h000;
         rd_reg    <= 1'b0;
         wr_reg    <= 1'b0;
         wdata_reg <= 32'h0000_0000;
         res_reg   <= 32'h0000_0000;
         line_reg  <= 10'h000;
         done_ev   <= 1'b0;
         err_ev    <= 1'b0;
      end else begin
         done_ev <= 1'b0;
         err_ev  <= 1'b0;
         case (state_reg)
            GVM_IDLE: begin
               if (go) begin
                  if (tgt_reg[1:0] != 2'b00) begin
                     err_ev <= 1'b1;
                  end else if (pwdata[GVM_WR_BIT]) begin
                     addr_reg  <= GVM_STS_OFS;
                     rd_reg    <= 1'b1;
                     state_reg <= GVM_POLL;
                  end else begin
                     addr_reg  <= tgt_reg;
                     rd_reg    <= 1'b1;
                     state_reg <= GVM_XFER;
                  end
               end
            end
            GVM_POLL: begin
               if (bus.ack) begin
                  line_reg <= bus.rdata[GVM_V_MSB:GVM_V_LSB];
                  if (bus.rdata[GVM_V_MSB:GVM_V_LSB] >= GVM_V_BLANK) begin
                     rd_reg    <= 1'b0;
                     wr_reg    <= 1'b1;
                     addr_reg  <= tgt_reg;
                     wdata_reg <= wlo_reg;
                     state_reg <= GVM_XFER;
                  end
               end
            end
            GVM_XFER: begin
               if (bus.ack) begin
                  if (rd_reg) begin
                     res_reg <= bus.rdata;
                  end
                  if (wr_reg && cpair_reg) begin
                     addr_reg  <= tgt_reg + GVM_WORD;
                     wdata_reg <= whi_reg;
                     state_reg <= GVM_XFER2;
                  end else begin
                     rd_reg    <= 1'b0;
                     wr_reg    <= 1'b0;
                     done_ev   <= 1'b1;
                     state_reg <= GVM_IDLE;
                  end
               end
            end
            GVM_XFER2: begin
               if (bus.ack) begin
                  wr_reg    <= 1'b0;
                  done_ev   <= 1'b1;
                  state_reg <= GVM_IDLE;
               end
            end
            default: begin
               state_reg <= GVM_IDLE;
            end
         endcase
      end
   end

endmodule : gvm_host
`default_nettype wire

// ---- verification/gvm_link_monitor.sv ----
// Checker for the word link between controller and video block.
// Assumes it sits beside the link interface, on the single clock.
`default_nettype none
module gvm_link_monitor (
   input wire logic                       pclk,
   input wire logic                       presetn,
   input wire logic [gvm_pkg::GVM_AW-1:0] addr,
   input wire logic                       rd,
   input wire logic                       wr,
   input wire logic [31:0]                wdata,
   input wire logic [31:0]                rdata,
   input wire logic                       ack
);
   import gvm_pkg::*;
   logic [9:0] seen_line_reg;
   wire logic  sts_ack = ack && rd && addr == GVM_STS_OFS;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // Line count of the latest status answer
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         seen_line_reg <= 10'h000;
      end else if (sts_ack) begin
         seen_line_reg <= rdata[19:10];
      end
   end
   // ************************************************************
   // Link handshake
   // ************************************************************
   sequence s_take; (rd || wr) && !ack; endsequence
   sequence s_answer; ack ##1 !ack; endsequence
   a_take_then_ack: assert property (s_take |=> s_answer)
      else $error("link request not answered by one ack pulse");
   a_ack_has_cause: assert property (ack |-> $past(rd || wr))
      else $error("ack without a request");
   a_req_held: assert property (s_take |=> $stable(addr) && $stable(wdata)
      && rd == $past(rd) && wr == $past(wr)) else $error("request changed before ack");
   a_one_kind: assert property (!(rd && wr))
      else $error("read and write raised together");
   a_cfg_unused_zero: assert property (wr && addr == GVM_CFG_OFS
      |-> (wdata >> (GVM_CLIP_MSB + 1)) == 32'h0) else $error("config unused bits set");
   // ************************************************************
   // Read data and write gating
   // ************************************************************
   a_cfg_reads_zero: assert property (ack && rd && addr == GVM_CFG_OFS |-> rdata == 32'h0)
      else $error("write-only config read not zero");
   a_status_fields: assert property (sts_ack |-> rdata[31:24] == 8'h00
      && rdata[23:20] <= 4'h4 && rdata[9:0] <= GVM_H_LAST && rdata[19:10] <= GVM_V_LAST)
      else $error("status word field out of range");
   a_write_in_blank: assert property (wr |-> seen_line_reg >= GVM_V_BLANK)
      else $error("write issued outside vertical blanking");
   a_unmapped_zero: assert property (ack && rd && addr > GVM_STS_OFS
      && addr < GVM_TAB_BASE |-> rdata == 32'h0) else $error("unmapped read not zero");
endmodule : gvm_link_monitor
`default_nettype wire

// ---- verification/game_video_mmio_regs_test.sv ----
// Testbench: APB controller and video block joined by the link.
// Assumes package, interface, design and monitor compiled first.
`default_nettype none
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin bad_count++; \
   $display("FAIL %s exp %h got %h", n, e, g); end end
module game_video_mmio_regs_test;
   timeunit 1ns;
   timeprecision 1ns;
   import gvm_pkg::*;
   localparam logic [9:0]  SIM_H_LAST = 10'h01f;  // Short lines keep frames brief
   logic                   pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
   logic                   pwrite = 1'b0, pready, pslverr, irq, hit_check_en, audio_start;
   logic [31:0]            paddr = 32'h0, pwdata = 32'h0, prdata, q;
   logic [7:0]             tile_palette = 8'h11, pixel_palette;
   logic [GVM_NSPR*8-1:0]  sprite_palette = {{11{8'h44}}, 8'h55, {4{8'h44}}};
   logic [3:0]             hit_class = 4'h3;
   logic [9:0]             scan_x, scan_y;
   logic [1:0]             tilemap_sel, audio_clip;
   logic [GVM_NSPR*64-1:0] active_table;
   int                     bad_count = 0;
   int                     num_checks = 0;
   gvm_if link ();
   gvm_device #(.H_LAST(SIM_H_LAST)) i_gvm_device (.pclk(pclk), .presetn(presetn), .bus(link),
      .tile_palette(tile_palette), .sprite_palette(sprite_palette), .hit_class(hit_class),
      .scan_x(scan_x), .scan_y(scan_y), .tilemap_sel(tilemap_sel), .hit_check_en(hit_check_en),
      .audio_clip(audio_clip), .audio_start(audio_start), .pixel_palette(pixel_palette),
      .active_table(active_table));
   gvm_host i_gvm_host (.pclk(pclk), .presetn(presetn), .bus(link), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .irq(irq));
   gvm_link_monitor i_gvm_link_monitor (.pclk(pclk), .presetn(presetn), .addr(link.addr),
      .rd(link.rd), .wr(link.wr), .wdata(link.wdata), .rdata(link.rdata), .ack(link.ack));
   // Free running clock, 50 ns period
   always #25 pclk = ~pclk;
   // ************************************************************
   // Bus and command tasks
   // ************************************************************
   task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      q = prdata;
      psel    <= 1'b0;
      penable <= 1'b0;
      #1;
   endtask : apb
   // Load target and data, start, then poll busy until idle
   task automatic cmd(input logic [31:0] t, lo, hi, c);
      int n;
      n = 0;
      apb(1'b1, GVM_A_TGT, t);
      apb(1'b1, GVM_A_WLO, lo);
      apb(1'b1, GVM_A_WHI, hi);
      apb(1'b1, GVM_A_CMD, c);
      do apb(1'b0, GVM_A_STATE, 32'h0); while (q[0] !== 1'b0 && ++n < 200000);
   endtask : cmd
   task automatic tick(input int k);
      repeat (k) begin @(posedge pclk); #1; end
   endtask : tick
   // Wait until just after the frame start edge
   task automatic to_frame;
      while (scan_x !== SIM_H_LAST || scan_y !== GVM_V_LAST) tick(1);
      tick(1);
   endtask : to_frame
   // ************************************************************
   // Scenarios
   // ************************************************************
   task t_read;
      `CHK("reset cfg", 5'h00, {audio_clip, hit_check_en, tilemap_sel})
      cmd(32'h4, 32'h0, 32'h0, 32'h1);
      apb(1'b0, GVM_A_RES, 32'h0);
      `CHK("class off", 4'h0, q[23:20])
      `CHK("early line", 1'b1, q[19:10] < 10'h1e0)
      `CHK("top byte", 8'h00, q[31:24])
      cmd(32'h0, 32'h0, 32'h0, 32'h1);
      apb(1'b0, GVM_A_RES, 32'h0);
      `CHK("cfg read", 32'h0, q)
      cmd(32'h100, 32'h0, 32'h0, 32'h1);
      apb(1'b0, GVM_A_RES, 32'h0);
      `CHK("unmapped", 32'h0, q)
   endtask : t_read
   task t_irq;
      apb(1'b1, GVM_A_IMASK, 32'h0);
      apb(1'b0, GVM_A_ISTAT, 32'h0);
      cmd(32'h702, 32'h0, 32'h0, 32'h1);
      `CHK("masked irq", 1'b0, irq)
      apb(1'b1, GVM_A_IMASK, 32'h2);
      `CHK("irq up", 1'b1, irq)
      apb(1'b0, GVM_A_ISTAT, 32'h0);
      `CHK("align flag", 2'h2, q[1:0])
      `CHK("irq cleared", 1'b0, irq)
      `CHK("no slave err", 1'b0, pslverr)
   endtask : t_irq
   task t_blank;
      int n;
      cmd(32'h0, 32'h15, 32'h0, 32'h3);
      `CHK("blank line", 1'b1, q[10:1] >= 10'h1e0)
      cmd(32'h718, 32'h0, 32'hffff_0500, 32'h7);
      cmd(32'h720, 32'h0, 32'hffff_0600, 32'h7);
      cmd(32'h71c, 32'h0, 32'h0, 32'h1);
      apb(1'b0, GVM_A_RES, 32'h0);
      `CHK("table read", 32'hffff_0500, q)
      `CHK("not yet", 3'h0, {hit_check_en, tilemap_sel})
      to_frame;
      `CHK("map one", 2'h1, tilemap_sel)
      `CHK("check on", 1'b1, hit_check_en)
      `CHK("clip", 2'h2, audio_clip)
      `CHK("entry", 64'hffff_0500_0000_0000, active_table[3*64+:64])
      n = 0;
      repeat (4) begin n += int'(audio_start === 1'b1); tick(1); end
      `CHK("clip start", 1, n)
      cmd(32'h4, 32'h0, 32'h0, 32'h1);
      apb(1'b0, GVM_A_RES, 32'h0);
      `CHK("class on", 4'h3, q[23:20])
      cmd(32'h0, 32'h17, 32'h0, 32'h3);
      to_frame;
      `CHK("map kept", 2'h1, tilemap_sel)
      `CHK("clip again", 1'b1, audio_start)
   endtask : t_blank
   task t_pixel;
      while (scan_y !== 10'h00a) tick(1);
      tick(4);
      `CHK("top rank", 8'h55, pixel_palette)
      @(posedge pclk);
      sprite_palette[4*8+:8] <= 8'h00;
      tick(4);
      `CHK("sprite pix", 8'h44, pixel_palette)
      @(posedge pclk);
      sprite_palette <= '0;
      tick(4);
      `CHK("clear pix", 8'h11, pixel_palette)
   endtask : t_pixel
   task close_out;
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : close_out
   // Main sequence after ten cycles of reset
   initial begin
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      #1;
      t_read;
      t_irq;
      t_blank;
      t_pixel;
      close_out;
   end
   // Watchdog near twice the expected run
   initial begin
      #3_000_000;
      bad_count++;
      close_out;
   end
endmodule : game_video_mmio_regs_test
`default_nettype wire
